// file: inc/uart_rxq_defines.vh
`ifndef UART_RXQ_DEFINES_VH
`define UART_RXQ_DEFINES_VH

// Register indices (byte address is four times the index)
`define POWER_CONTROL_IDX       8'h87
`define SERIAL_CONTROL_IDX      8'h98
`define SERIAL_DATA_IDX         8'h99
`define BAUD_CONTROL_IDX        8'h9b
`define SLAVE_ADDRESS_VALUE_IDX 8'ha9
`define SLAVE_ADDRESS_MASK_IDX  8'hb9

// Byte addresses on the APB
`define POWER_CONTROL_ADDR       12'h21c
`define SERIAL_CONTROL_ADDR      12'h260
`define SERIAL_DATA_ADDR         12'h264
`define BAUD_CONTROL_ADDR        12'h26c
`define SLAVE_ADDRESS_VALUE_ADDR 12'h2a4
`define SLAVE_ADDRESS_MASK_ADDR  12'h2e4

// Serial control fields
`define SC_BIT7   7
`define SC_MODE1  6
`define SC_MPEN   5
`define SC_REN    4
`define SC_TB8    3
`define SC_RB8    2
`define SC_TI     1
`define SC_RI     0

// Power control fields
`define PC_BAUD_DOUBLE 7
`define PC_ERR_SELECT  6

// Baud control fields
`define BC_RBCK 2
`define BC_SRC  0
`define BC_WIDTH 5

// Reset values
`define SERIAL_CONTROL_RST      8'h00
`define POWER_CONTROL_RST       2'h0
`define BAUD_CONTROL_RST        5'h00
`define SLAVE_ADDRESS_VALUE_RST 8'h00
`define SLAVE_ADDRESS_MASK_RST  8'h00

// Mode 0 bit periods, in source events
`define M0_DIV_FAST      3'h4
`define M0_DIV_FAST_X2   3'h2
`define M0_DIV_COMPAT    3'h6
`define M0_DIV_COMPAT_X2 3'h3
`define M0_DIV_T1        3'h4
`define M0_DIV_T1_X2     3'h2
`define M0_DIV_BRG       3'h2
`define M0_DIV_BRG_X2    3'h1

// Mid-bit sample points of the 16x oversampler
`define SMP_FIRST  4'h7
`define SMP_SECOND 4'h8
`define SMP_LAST   4'h9

`endif

// file: core/uart_rxq.v
`timescale 1ns/1ns
`include "uart_rxq_defines.vh"
// What this block does
// (R1) Missing stop bit sets framing error flag
// (R2) Control bit 7 is error or mode bit
// (R3) Framing error flag cleared only by software
// (R4) Framing error sets regardless of error select
// (R5) Address filter only with enable, modes 1-3
// (R6) Nine-bit: ninth bit one and address match
// (R7) Mode 1: valid stop bit and address match
// (R8) Given match compares masked bit positions only
// (R9) Broadcast is address OR mask, zeros ignored
// (R10) Address and mask registers reset to zero
// (R11) Mode 0: half duplex, eight bits, LSB first
// (R12) Mode 0 fast: clock divided by 4 or 2
// (R13) Mode 0 compat: clock divided by 6 or 3
// (R14) Mode 0 timer 1: overflow divided by 4 or 2
// (R15) Mode 0 generator: overflow divided by 2 or 1
// (R16) Mode 0 clock idle level and data edges
// (R17) Framing error is stop-bit majority vote zero
// (R18) Master sends addresses with ninth bit set
module uart_rxq (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Baud sources and timing mode
  input  wire        timer1_ovf,
  input  wire        brg_ovf,
  input  wire        compat_timing,
  // Serial pins
  input  wire        rxd_in,
  output wire        rxd_out,
  output wire        rxd_oe,
  output reg         txd_out
);
  function given_match;
    input [7:0] b;
    input [7:0] adr;
    input [7:0] msk;
    given_match = (((b ^ adr) & msk) == 8'h00); // see (R8)
  endfunction
  function bcast_match;
    input [7:0] b;
    input [7:0] adr;
    input [7:0] msk;
    bcast_match = ((~b & (adr | msk)) == 8'h00); // see (R9)
  endfunction
  localparam [3:0] RX_IDLE = 4'b0001;
  localparam [3:0] RX_BITS = 4'b0010;
  reg  [7:0] slave_address_value_q;
  reg  [7:0] slave_address_mask_q;
  reg        mode_select_high_q;
  reg        mode_low_q;
  reg        multiproc_enable_q;
  reg        ren_q;
  reg        tx_ninth_bit_q;
  reg        rb8_q;
  reg        ti_q;
  reg        receive_done_flag_q;
  reg        framing_error_flag_q;
  reg        baud_double_q;
  reg        error_flag_select_q;
  reg  [4:0] baud_control_q;
  reg  [7:0] serial_data_q;
  reg        rxd_m_q;
  reg        rxd_s_q;
  reg        rxd_p_q;
  reg  [3:0] rx_state_q;
  reg  [3:0] smp_q;
  reg  [3:0] bitn_q;
  reg  [1:0] vote_q;
  reg  [7:0] rx_sh_q;
  reg        rx_ninth_q;
  reg        m2_div_q;
  reg        m0_busy_q;
  reg        m0_tx_q;
  reg        m0_active_q;
  reg  [2:0] m0_bit_q;
  reg  [2:0] m0_ph_q;
  reg        m0_lead_q;
  reg  [7:0] m0_sh_q;
  reg  [2:0] m0_div;
  reg        m0_ev;
  reg        set_ri;
  reg        set_ti;
  reg        set_fe;
  reg        load_rx;
  reg  [7:0] rdata;
  reg        mapped;
  wire       wr_en     = psel & penable & pwrite;
  wire       mode0     = ~mode_select_high_q & ~mode_low_q;
  wire       nine_bit  = mode_select_high_q;
  wire       src_brg   = baud_control_q[`BC_SRC];
  wire       rx_tick   = (mode_select_high_q & ~mode_low_q) ? (baud_double_q | m2_div_q) :
                         (baud_control_q[`BC_RBCK] ? brg_ovf : timer1_ovf);
  wire       majority  = (vote_q[0] & vote_q[1]) | (vote_q[0] & rxd_s_q) |
                         (vote_q[1] & rxd_s_q); // see (R17)
  wire       addr_ok   = given_match(rx_sh_q, slave_address_value_q, slave_address_mask_q) |
                         bcast_match(rx_sh_q, slave_address_value_q, slave_address_mask_q);
  wire       bit_done  = (rx_state_q == RX_BITS) & rx_tick & (smp_q == `SMP_LAST);
  wire       stop_bit  = bit_done & (bitn_q == (nine_bit ? 4'd10 : 4'd9));
  wire       m0_lead   = m0_busy_q & ~m0_active_q & m0_ev & (m0_ph_q == 3'h0);
  wire       m0_trail  = m0_busy_q & m0_active_q &
                         ((m0_div == 3'h1) ? m0_lead_q : (m0_ev & (m0_ph_q == (m0_div >> 1))));
  wire       lead_chg  = ~multiproc_enable_q & baud_double_q; // see (R16)
  wire       lead_smp  = multiproc_enable_q & baud_double_q; // see (R16)
  wire       m0_sample = lead_smp ? m0_lead : m0_trail;
  wire       m0_change = lead_chg ? (m0_lead & (m0_bit_q != 3'h0)) : m0_trail;
  wire       sd_write  = wr_en & (paddr == `SERIAL_DATA_ADDR);
  wire       m0_start_tx = mode0 & ~m0_busy_q & sd_write; // see (R11)
  wire       m0_start_rx = mode0 & ~m0_busy_q & ~sd_write & ren_q & ~receive_done_flag_q;
  wire       m0_end    = m0_trail & (m0_bit_q == 3'h7);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign rxd_out = m0_sh_q[0];
  assign rxd_oe  = m0_busy_q & m0_tx_q; // see (R11)

  // Mode 0 bit period and event source
  always @* begin
    if (src_brg) begin
      m0_div = baud_double_q ? `M0_DIV_BRG_X2 : `M0_DIV_BRG; // see (R15)
      m0_ev  = brg_ovf;
    end else if (tx_ninth_bit_q) begin
      m0_div = baud_double_q ? `M0_DIV_T1_X2 : `M0_DIV_T1; // see (R14)
      m0_ev  = timer1_ovf;
    end else if (compat_timing) begin
      m0_div = baud_double_q ? `M0_DIV_COMPAT_X2 : `M0_DIV_COMPAT; // see (R13)
      m0_ev  = 1'b1;
    end else begin
      m0_div = baud_double_q ? `M0_DIV_FAST_X2 : `M0_DIV_FAST; // see (R12)
      m0_ev  = 1'b1;
    end
  end

  // Frame qualification at the stop bit
  always @* begin
    set_fe  = stop_bit & ~majority; // see (R1) (R4)
    load_rx = 1'b0;
    if (stop_bit & ~receive_done_flag_q) begin
      if (~multiproc_enable_q)
        load_rx = 1'b1;
      else if (nine_bit)
        load_rx = rx_ninth_q & addr_ok; // see (R5) (R6) (R18)
      else
        load_rx = majority & addr_ok; // see (R5) (R7)
    end
    set_ri = load_rx | (m0_end & ~m0_tx_q);
    set_ti = m0_end & m0_tx_q;
  end

  // Register read decode
  always @* begin
    mapped = 1'b1;
    rdata  = 8'h00;
    case (paddr)
      `SERIAL_CONTROL_ADDR:
        rdata = {error_flag_select_q ? framing_error_flag_q : mode_select_high_q, // see (R2)
                 mode_low_q, multiproc_enable_q, ren_q, tx_ninth_bit_q, rb8_q, ti_q,
                 receive_done_flag_q};
      `SERIAL_DATA_ADDR:         rdata = serial_data_q;
      `POWER_CONTROL_ADDR:       rdata = {baud_double_q, error_flag_select_q, 6'h00};
      `BAUD_CONTROL_ADDR:        rdata = {3'h0, baud_control_q};
      `SLAVE_ADDRESS_VALUE_ADDR: rdata = slave_address_value_q;
      `SLAVE_ADDRESS_MASK_ADDR:  rdata = slave_address_mask_q;
      default:                   mapped = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= {24'h00_0000, rdata};
    end
  end

  // Software registers and hardware flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_address_value_q <= `SLAVE_ADDRESS_VALUE_RST; // see (R10)
      slave_address_mask_q  <= `SLAVE_ADDRESS_MASK_RST; // see (R10)
      {mode_select_high_q, mode_low_q, multiproc_enable_q, ren_q,
       tx_ninth_bit_q, rb8_q, ti_q, receive_done_flag_q} <= `SERIAL_CONTROL_RST;
      framing_error_flag_q <= 1'b0;
      {baud_double_q, error_flag_select_q} <= `POWER_CONTROL_RST;
      baud_control_q <= `BAUD_CONTROL_RST;
      serial_data_q  <= 8'h00;
    end else begin
      if (wr_en) begin
        case (paddr)
          `SERIAL_CONTROL_ADDR: begin
            if (error_flag_select_q)
              framing_error_flag_q <= pwdata[`SC_BIT7] | set_fe; // see (R2) (R3)
            else
              mode_select_high_q <= pwdata[`SC_BIT7]; // see (R2)
            mode_low_q          <= pwdata[`SC_MODE1];
            multiproc_enable_q  <= pwdata[`SC_MPEN];
            ren_q               <= pwdata[`SC_REN];
            tx_ninth_bit_q      <= pwdata[`SC_TB8];
            rb8_q               <= load_rx ? (nine_bit ? rx_ninth_q : majority) :
                                   pwdata[`SC_RB8];
            ti_q                <= pwdata[`SC_TI] | set_ti;
            receive_done_flag_q <= pwdata[`SC_RI] | set_ri;
          end
          `POWER_CONTROL_ADDR: begin
            baud_double_q       <= pwdata[`PC_BAUD_DOUBLE];
            error_flag_select_q <= pwdata[`PC_ERR_SELECT];
          end
          `BAUD_CONTROL_ADDR:        baud_control_q <= pwdata[`BC_WIDTH-1:0];
          `SLAVE_ADDRESS_VALUE_ADDR: slave_address_value_q <= pwdata[7:0];
          `SLAVE_ADDRESS_MASK_ADDR:  slave_address_mask_q <= pwdata[7:0];
          default: ;
        endcase
      end
      // Hardware sets win over a software clear in the same cycle
      if (set_fe)
        framing_error_flag_q <= 1'b1; // see (R1) (R3) (R4)
      if (set_ri)
        receive_done_flag_q <= 1'b1;
      if (set_ti)
        ti_q <= 1'b1;
      if (load_rx) begin
        serial_data_q <= rx_sh_q;
        rb8_q         <= nine_bit ? rx_ninth_q : majority;
      end else if (m0_end & ~m0_tx_q) begin
        serial_data_q <= m0_sample ? {rxd_s_q, m0_sh_q[7:1]} : m0_sh_q;
      end
    end
  end

  // Receiver for modes 1, 2 and 3 with 16x oversampling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_m_q    <= 1'b1;
      rxd_s_q    <= 1'b1;
      rxd_p_q    <= 1'b1;
      rx_state_q <= RX_IDLE;
      smp_q      <= 4'h0;
      bitn_q     <= 4'h0;
      vote_q     <= 2'h0;
      rx_sh_q    <= 8'h00;
      rx_ninth_q <= 1'b0;
      m2_div_q   <= 1'b0;
    end else begin
      rxd_m_q  <= rxd_in;
      rxd_s_q  <= rxd_m_q;
      rxd_p_q  <= rxd_s_q;
      m2_div_q <= ~m2_div_q;
      case (rx_state_q)
        RX_IDLE: begin
          if (~mode0 & ren_q & rxd_p_q & ~rxd_s_q) begin
            rx_state_q <= RX_BITS;
            smp_q      <= 4'h0;
            bitn_q     <= 4'h0;
          end
        end
        RX_BITS: begin
          if (mode0 | ~ren_q) begin
            rx_state_q <= RX_IDLE;
          end else if (rx_tick) begin
            smp_q <= smp_q + 4'h1;
            if (smp_q == `SMP_FIRST)
              vote_q[0] <= rxd_s_q;
            if (smp_q == `SMP_SECOND)
              vote_q[1] <= rxd_s_q;
            if (smp_q == `SMP_LAST) begin
              bitn_q <= bitn_q + 4'h1;
              if (bitn_q == 4'h0) begin
                if (majority)
                  rx_state_q <= RX_IDLE;
              end else if (bitn_q <= 4'h8) begin
                rx_sh_q <= {majority, rx_sh_q[7:1]};
              end else if (nine_bit & (bitn_q == 4'h9)) begin
                rx_ninth_q <= majority;
              end else begin
                rx_state_q <= RX_IDLE;
              end
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Mode 0 synchronous shifter, shift clock on the transmit pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_busy_q   <= 1'b0;
      m0_tx_q     <= 1'b0;
      m0_active_q <= 1'b0;
      m0_bit_q    <= 3'h0;
      m0_ph_q     <= 3'h0;
      m0_lead_q   <= 1'b0;
      m0_sh_q     <= 8'h00;
      txd_out     <= 1'b1;
    end else begin
      m0_lead_q <= m0_lead;
      if (m0_start_tx | m0_start_rx) begin
        m0_busy_q   <= 1'b1;
        m0_tx_q     <= m0_start_tx;
        m0_active_q <= 1'b0;
        m0_bit_q    <= 3'h0;
        m0_ph_q     <= 3'h0;
        m0_sh_q     <= m0_start_tx ? pwdata[7:0] : 8'h00;
      end else if (m0_busy_q) begin
        if (m0_ev)
          m0_ph_q <= (m0_ph_q == m0_div - 3'h1) ? 3'h0 : m0_ph_q + 3'h1;
        if (m0_lead) begin
          m0_active_q <= 1'b1;
          txd_out     <= multiproc_enable_q; // see (R16)
        end
        if (m0_trail) begin
          m0_active_q <= 1'b0;
          txd_out     <= ~multiproc_enable_q; // see (R16)
          m0_bit_q    <= m0_bit_q + 3'h1;
          if (m0_end)
            m0_busy_q <= 1'b0;
        end
        if (m0_tx_q & m0_change)
          m0_sh_q <= {1'b0, m0_sh_q[7:1]}; // see (R11)
        else if (~m0_tx_q & m0_sample)
          m0_sh_q <= {rxd_s_q, m0_sh_q[7:1]}; // see (R11)
      end else begin
        txd_out <= mode0 ? ~multiproc_enable_q : 1'b1; // see (R16)
      end
    end
  end

endmodule // uart_rxq

// file: verif/uart_rxq_asserts.sv
`timescale 1ns/1ns
`include "uart_rxq_defines.vh"
module uart_rxq_asserts (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // Serial pins
  input wire        rxd_out,
  input wire        rxd_oe,
  input wire        txd_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       acc = psel & penable;
  wire       hit = paddr == `POWER_CONTROL_ADDR || paddr == `SERIAL_CONTROL_ADDR ||
                   paddr == `SERIAL_DATA_ADDR || paddr == `BAUD_CONTROL_ADDR ||
                   paddr == `SLAVE_ADDRESS_VALUE_ADDR || paddr == `SLAVE_ADDRESS_MASK_ADDR;
  reg  [7:0] oe_q;
  // Length of the current drive of the data pin
  always @(posedge pclk or negedge presetn)
    if (!presetn) oe_q <= 8'h00;
    else oe_q <= rxd_oe ? oe_q + 8'h01 : 8'h00;
  property p_rst; $rose(presetn) |-> prdata == 32'h0 && txd_out && !rxd_oe; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err; acc |-> pslverr == !hit; endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_noerr; !acc |-> !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("error outside access");
  property p_hi; 1'b1 |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_hold; acc |-> ##1 prdata == $past(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data not held");
  property p_clk; $rose(rxd_oe) |-> ##[0:16] $changed(txd_out); endproperty
  a_clk: assert property (p_clk) else $error("no shift clock");
  property p_len; 1'b1 |-> oe_q <= 8'h50; endproperty
  a_len: assert property (p_len) else $error("transmit too long");
  property p_sync; rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> $changed(txd_out); endproperty
  a_sync: assert property (p_sync) else $error("data off clock edge");
endmodule // uart_rxq_asserts

bind uart_rxq uart_rxq_asserts i_uart_rxq_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));

// file: verif/uart_line_node.sv
`timescale 1ns/1ns
module uart_line_node (
  // Clock
  input wire pclk,
  // Serial line towards the block, idles high
  output reg line_q
);
  initial line_q = 1'b1;
  task automatic send(input [7:0] d, input nine, input use9, input stp, input int bc);
    reg [10:0] f;
    int        n;
    begin
      f = {stp, nine, d, 1'b0};
      n = use9 ? 11 : 10;
      if (!use9) f[9] = stp;
      for (int i = 0; i < n; i++) begin
        @(posedge pclk);
        line_q <= f[i];
        repeat (bc - 1) @(posedge pclk);
      end
      @(posedge pclk);
      line_q <= 1'b1;
    end
  endtask
endmodule // uart_line_node

// file: verif/uart_addr_filter_mode0_baud_bench.sv
`timescale 1ns/1ns
`include "uart_rxq_defines.vh"
module uart_addr_filter_mode0_baud_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         compat = 1'b0;
  reg  [2:0]  ph = 3'h0;
  wire        pready, pslverr, rxd_out, rxd_oe, txd_out, line;
  wire [31:0] prdata;
  wire        rxd_w = rxd_oe ? rxd_out : line;
  int         n_errors = 0;
  int         n_checks = 0;
  int         cyc = 0;
  always #5 pclk = ~pclk;
  // Timer overflow every 2nd clock, generator overflow every 3rd
  always @(posedge pclk) ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
  uart_rxq i_uart_rxq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .timer1_ovf(~ph[0]), .brg_ovf(ph == 3'h0 || ph == 3'h3),
    .compat_timing(compat), .rxd_in(rxd_w), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out));
  uart_line_node i_uart_line_node (.pclk(pclk), .line_q(line));
  task automatic tally_and_finish;
    begin
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input [31:0] g, input [31:0] e);
    begin
      n_checks++;
      if (g !== e) begin
        n_errors++;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic apb(input [11:0] a, input w, input [31:0] d, output [31:0] r);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input [11:0] a, input [7:0] d);
    reg [31:0] r;
    apb(a, 1'b1, {24'h0, d}, r);
  endtask
  task automatic rd(input [11:0] a, output [31:0] r);
    apb(a, 1'b0, 32'h0, r);
  endtask
  task automatic rx(input [7:0] d, input n9, input u9, input s, input int bc, input ri,
                    input [7:0] scv);
    reg [31:0] r;
    begin
      i_uart_line_node.send(d, n9, u9, s, bc);
      repeat (4) @(posedge pclk);
      rd(`SERIAL_CONTROL_ADDR, r);
      chk(r & 32'h1, {31'h0, ri});
      rd(`SERIAL_DATA_ADDR, r);
      if (ri) chk(r, {24'h0, d});
      wr(`SERIAL_CONTROL_ADDR, scv);
    end
  endtask
  task automatic t_regs;
    reg [31:0] r;
    begin
      rd(`SLAVE_ADDRESS_VALUE_ADDR, r);
      chk(r, 32'h0);
      rd(`SLAVE_ADDRESS_MASK_ADDR, r);
      chk(r, 32'h0);
      rd(12'h004, r);
      chk(r, 32'h0);
      wr(`POWER_CONTROL_ADDR, 8'h80);
      wr(`SERIAL_CONTROL_ADDR, 8'hb0);
      rx(8'h5a, 1'b1, 1'b1, 1'b1, 16, 1'b1, 8'hb0);
    end
  endtask
  task automatic t_fe;
    reg [31:0] r;
    begin
      wr(`POWER_CONTROL_ADDR, 8'h00);
      wr(`SERIAL_CONTROL_ADDR, 8'h50);
      rx(8'h3c, 1'b0, 1'b0, 1'b0, 32, 1'b1, 8'h50);
      rd(`SERIAL_CONTROL_ADDR, r);
      chk(r & 32'h80, 32'h0);
      wr(`POWER_CONTROL_ADDR, 8'h40);
      rd(`SERIAL_CONTROL_ADDR, r);
      chk(r & 32'h80, 32'h80);
      rx(8'h11, 1'b0, 1'b0, 1'b1, 32, 1'b1, 8'hd0);
      rd(`SERIAL_CONTROL_ADDR, r);
      chk(r & 32'h80, 32'h80);
      wr(`SERIAL_CONTROL_ADDR, 8'h50);
      rd(`SERIAL_CONTROL_ADDR, r);
      chk(r & 32'h80, 32'h0);
    end
  endtask
  task automatic t_addr;
    reg [7:0] d[5] = '{8'hc2, 8'hc1, 8'hc0, 8'hff, 8'h40};
    reg [4:0] n9 = 5'b11011;
    reg [4:0] ri = 5'b10010;
    begin
      wr(`POWER_CONTROL_ADDR, 8'h80);
      wr(`SERIAL_CONTROL_ADDR, 8'hb0);
      wr(`SLAVE_ADDRESS_VALUE_ADDR, 8'hc0);
      wr(`SLAVE_ADDRESS_MASK_ADDR, 8'hfd);
      for (int i = 0; i < 5; i++) rx(d[i], n9[4-i], 1'b1, 1'b1, 16, ri[4-i], 8'hb0);
    end
  endtask
  task automatic t_m1;
    begin
      wr(`POWER_CONTROL_ADDR, 8'h00);
      wr(`SERIAL_CONTROL_ADDR, 8'h70);
      rx(8'hc0, 1'b0, 1'b0, 1'b0, 32, 1'b0, 8'h70);
      rx(8'hc0, 1'b0, 1'b0, 1'b1, 32, 1'b1, 8'h70);
      rx(8'h12, 1'b0, 1'b0, 1'b1, 32, 1'b0, 8'h50);
      rx(8'h12, 1'b0, 1'b0, 1'b1, 32, 1'b1, 8'h50);
    end
  endtask
  task automatic t_m0;
    reg [7:0] pc[8] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80};
    reg [7:0] sc[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00};
    int       np[8] = '{4, 2, 6, 3, 8, 4, 6, 3};
    reg [7:0] b;
    int       nf, t0, t1, pv;
    reg [31:0] r;
    begin
      wr(`SERIAL_CONTROL_ADDR, 8'h20);
      repeat (2) @(posedge pclk);
      chk({31'h0, txd_out}, 32'h0);
      for (int i = 0; i < 8; i++) begin
        @(posedge pclk);
        compat <= (i == 2 || i == 3);
        wr(`POWER_CONTROL_ADDR, pc[i]);
        wr(`BAUD_CONTROL_ADDR, (i > 5) ? 8'h01 : 8'h00);
        wr(`SERIAL_CONTROL_ADDR, sc[i]);
        repeat (2) @(posedge pclk);
        chk({31'h0, txd_out}, 32'h1);
        wr(`SERIAL_DATA_ADDR, 8'ha5);
        nf = 0;
        pv = 1;
        for (int k = 0; k < 300 && !(nf == 8 && !rxd_oe); k++) begin
          @(posedge pclk);
          #1;
          if (pv && !txd_out && nf < 8) begin
            b[nf] = rxd_out;
            if (nf == 0) t0 = k;
            if (nf == 1) t1 = k;
            nf++;
          end
          pv = txd_out;
        end
        chk(t1 - t0, np[i]);
        if (pc[i] == 8'h00) chk({24'h0, b}, 32'ha5);
        rd(`SERIAL_CONTROL_ADDR, r);
        chk(r & 32'h2, 32'h2);
      end
      // Mode 0 receive from the idle-high line
      wr(`SERIAL_CONTROL_ADDR, 8'h10);
      repeat (60) @(posedge pclk);
      rd(`SERIAL_CONTROL_ADDR, r);
      chk(r & 32'h1, 32'h1);
      rd(`SERIAL_DATA_ADDR, r);
      chk(r, 32'hff);
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_fe;
    t_addr;
    t_m1;
    t_m0;
    tally_and_finish;
  end
endmodule // uart_addr_filter_mode0_baud_bench
